// [hdl/muxed_io_port.v]
`timescale 1ns/100ps
`default_nettype none
`include "muxed_port_consts.vh"

module muxed_io_port #(
	parameter WIDTH = 8,
	parameter ADDR_LINES_PRESENT = 1,
	parameter [0:0] PWM_MAP_SEL_RESET = `RST_PWM_MAP_SEL
)(
	input wire ref_clk_i,
	input wire rst_i,
	input wire [`ADDR_WIDTH-1:0] avs_address_i,
	input wire avs_read_i,
	input wire avs_write_i,
	input wire [31:0] avs_writedata_i,
	input wire [3:0] avs_byteenable_i,
	output reg [31:0] avs_readdata_o,
	output reg avs_waitrequest_o,
	input wire [WIDTH-1:0] pin_in_i,
	output reg [WIDTH-1:0] pin_out_o,
	output reg [WIDTH-1:0] pin_oe_o,
	input wire ext_mem_en_i,
	input wire [3:0] ext_addr_hi_i,
	input wire pwm3_channel_c_i,
	input wire pwm3_channel_b_i,
	input wire pwm1_channel_c_i,
	input wire pwm1_channel_b_i,
	input wire pwm_shutdown_i,
	output reg [3:0] analog_channel_sel_o,
	output reg [3:0] analog_port_config_field_o
);

	// ==========================================
	// Software visible state
	reg [WIDTH-1:0] output_latch;
	reg [WIDTH-1:0] direction_control;
	reg [3:0] analog_port_config_field;
	reg pwm_pin_map_select;
	reg pwm_shutdown_tristate;
	reg ext_mem_enable;

	wire [WIDTH-1:0] port_pin_levels;
	wire [WIDTH-1:0] next_out;
	wire [WIDTH-1:0] next_oe;
	wire [3:0] pwm_alt;
	wire [3:0] analog_sel;
	wire bus_req;
	wire bus_accept;
	wire lane0_write;
	reg [31:0] next_readdata;

	// ==========================================
	// Analog decode, shared by the sampler and the status output
	function [3:0] analog_decode;
		input [3:0] field;
		begin
			if (field <= `PCFG_ANALOG_MAX)
				analog_decode = 4'hF;
			else
				analog_decode = 4'h0;
		end
	endfunction

	assign analog_sel = analog_decode(analog_port_config_field);

	// Pin order 4..7 matches the alternate PWM channel order
	assign pwm_alt = {pwm1_channel_b_i, pwm1_channel_c_i, pwm3_channel_b_i, pwm3_channel_c_i};

	// ==========================================
	// Bus handshake
	// Idle waitrequest is high; the slave drops it one cycle after a request
	// appears and the request is taken on the edge where it is seen low.
	assign bus_req = avs_read_i | avs_write_i;
	assign bus_accept = bus_req & ~avs_waitrequest_o;
	assign lane0_write = bus_accept & avs_write_i & avs_byteenable_i[0];

	always @(posedge ref_clk_i)
	begin
		if (rst_i)
			avs_waitrequest_o <= 1'b1;
		else if (bus_req && avs_waitrequest_o)
			avs_waitrequest_o <= 1'b0;
		else
			avs_waitrequest_o <= 1'b1;
	end

	// ==========================================
	// Read mux, loaded the cycle before acceptance so data stand at that edge
	always @*
	begin
		next_readdata = 32'h00000000;
		case (avs_address_i)
			`ADDR_PIN_LEVELS:
				next_readdata[WIDTH-1:0] = port_pin_levels;
			`ADDR_OUT_LATCH:
				next_readdata[WIDTH-1:0] = output_latch;
			`ADDR_DIRECTION:
				next_readdata[WIDTH-1:0] = direction_control;
			`ADDR_PORT_CONFIG:
			begin
				next_readdata[`CFG_EXT_MEM_EN_BIT] = ext_mem_enable;
				next_readdata[`CFG_PWM_MAP_SEL_BIT] = pwm_pin_map_select;
				next_readdata[`CFG_PWM_SD_TRI_BIT] = pwm_shutdown_tristate;
				next_readdata[`CFG_PCFG_MSB:`CFG_PCFG_LSB] = analog_port_config_field;
			end
			default:
				next_readdata = 32'h00000000;
		endcase
	end

	always @(posedge ref_clk_i)
	begin
		if (rst_i)
			avs_readdata_o <= 32'h00000000;
		else if (avs_read_i && avs_waitrequest_o)
			avs_readdata_o <= next_readdata;
	end

	// ==========================================
	// Register writes; unmapped addresses and byte lanes above 0 are ignored
	always @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			output_latch <= `RST_OUT_LATCH;
			direction_control <= `RST_DIRECTION;
			analog_port_config_field <= `RST_PCFG;
			pwm_pin_map_select <= PWM_MAP_SEL_RESET;
			pwm_shutdown_tristate <= 1'b0;
			ext_mem_enable <= 1'b0;
		end
		else if (lane0_write)
		begin
			case (avs_address_i)
				`ADDR_PIN_LEVELS:
					output_latch <= avs_writedata_i[WIDTH-1:0];
				`ADDR_OUT_LATCH:
					output_latch <= avs_writedata_i[WIDTH-1:0];
				`ADDR_DIRECTION:
					direction_control <= avs_writedata_i[WIDTH-1:0];
				`ADDR_PORT_CONFIG:
				begin
					ext_mem_enable <= avs_writedata_i[`CFG_EXT_MEM_EN_BIT];
					pwm_pin_map_select <= avs_writedata_i[`CFG_PWM_MAP_SEL_BIT];
					pwm_shutdown_tristate <= avs_writedata_i[`CFG_PWM_SD_TRI_BIT];
					analog_port_config_field <= avs_writedata_i[`CFG_PCFG_MSB:`CFG_PCFG_LSB];
				end
				default:
					output_latch <= output_latch;
			endcase
		end
	end

	// ==========================================
	// Pin drive, registered so every pin output comes from a flip-flop
	port_pin_mux #(
		.WIDTH(WIDTH),
		.ADDR_LINES_PRESENT(ADDR_LINES_PRESENT)
	) u_mux (
		.latch_i(output_latch),
		.dir_i(direction_control),
		.ext_mem_en_i(ext_mem_enable | ext_mem_en_i),
		.ext_addr_hi_i(ext_addr_hi_i),
		.pwm_map_sel_i(pwm_pin_map_select),
		.pwm_sd_tri_i(pwm_shutdown_tristate),
		.pwm_shutdown_i(pwm_shutdown_i),
		.pwm_alt_i(pwm_alt),
		.next_out_o(next_out),
		.next_oe_o(next_oe)
	);

	// Analog selection does not gate the driver: digital output stays usable
	always @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			pin_out_o <= {WIDTH{1'b0}};
			pin_oe_o <= {WIDTH{1'b0}};
			analog_channel_sel_o <= 4'h0;
			analog_port_config_field_o <= `RST_PCFG;
		end
		else
		begin
			pin_out_o <= next_out;
			pin_oe_o <= next_oe;
			analog_channel_sel_o <= analog_sel;
			analog_port_config_field_o <= analog_port_config_field;
		end
	end

	// ==========================================
	// Pin sampling for the port data register
	port_pin_sampler #(
		.WIDTH(WIDTH)
	) u_sampler (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.pins_i(pin_in_i),
		.analog_sel_i(analog_sel),
		.levels_o(port_pin_levels)
	);

endmodule // muxed_io_port
`default_nettype wire

// [pkg/muxed_port_consts.vh]
`ifndef MUXED_PORT_CONSTS_VH
`define MUXED_PORT_CONSTS_VH

// ==========================================
// Register byte addresses
`define ADDR_PIN_LEVELS 4'h0
`define ADDR_OUT_LATCH 4'h4
`define ADDR_DIRECTION 4'h8
`define ADDR_PORT_CONFIG 4'hC
`define ADDR_WIDTH 4

// ==========================================
// Port configuration register fields
`define CFG_EXT_MEM_EN_BIT 0
`define CFG_PWM_MAP_SEL_BIT 1
`define CFG_PWM_SD_TRI_BIT 2
`define CFG_PCFG_LSB 4
`define CFG_PCFG_MSB 7

// ==========================================
// Reset values
`define RST_DIRECTION 8'hFF
`define RST_OUT_LATCH 8'h00
`define RST_PCFG 4'h0
`define RST_PWM_MAP_SEL 1'h1

// ==========================================
// Analog decode: field values up to this one make channels 12..15 analog
`define PCFG_ANALOG_MAX 4'h2

// ==========================================
// Pin groups
`define PORT_WIDTH 8
`define ADDR_PIN_COUNT 4
`define ANALOG_PIN_LSB 4

`endif

// [hdl/port_pin_mux.v]
`timescale 1ns/100ps
`default_nettype none
`include "muxed_port_consts.vh"

module port_pin_mux #(
	parameter WIDTH = 8,
	parameter ADDR_LINES_PRESENT = 1
)(
	input wire [WIDTH-1:0] latch_i,
	input wire [WIDTH-1:0] dir_i,
	input wire ext_mem_en_i,
	input wire [3:0] ext_addr_hi_i,
	input wire pwm_map_sel_i,
	input wire pwm_sd_tri_i,
	input wire pwm_shutdown_i,
	input wire [3:0] pwm_alt_i,
	output reg [WIDTH-1:0] next_out_o,
	output reg [WIDTH-1:0] next_oe_o
);

	integer i;

	// ==========================================
	// Per-pin source selection, lowest priority first
	always @*
	begin
		for (i = 0; i < WIDTH; i = i + 1)
		begin
			next_out_o[i] = latch_i[i];
			next_oe_o[i] = ~dir_i[i];
			if (i < `ADDR_PIN_COUNT)
			begin
				// Address lines ignore direction entirely
				if (ext_mem_en_i && (ADDR_LINES_PRESENT != 0))
				begin
					next_out_o[i] = ext_addr_hi_i[i];
					next_oe_o[i] = 1'b1;
				end
			end
			else if (!pwm_map_sel_i)
			begin
				// Software must still clear the direction bit to see the output
				next_out_o[i] = pwm_alt_i[i-`ANALOG_PIN_LSB];
				if (pwm_sd_tri_i && pwm_shutdown_i)
					next_oe_o[i] = 1'b0;
			end
		end
	end

endmodule // port_pin_mux
`default_nettype wire

// [hdl/port_pin_sampler.v]
`timescale 1ns/100ps
`default_nettype none
`include "muxed_port_consts.vh"

module port_pin_sampler #(
	parameter WIDTH = 8
)(
	input wire ref_clk_i,
	input wire rst_i,
	input wire [WIDTH-1:0] pins_i,
	input wire [3:0] analog_sel_i,
	output reg [WIDTH-1:0] levels_o
);

	// ==========================================
	// Analog pins read as zero on the digital path
	always @(posedge ref_clk_i)
	begin
		if (rst_i)
			levels_o <= {WIDTH{1'b0}};
		else
			levels_o <= pins_i & ~({analog_sel_i, 4'h0});
	end

endmodule // port_pin_sampler
`default_nettype wire

// [testbench/muxed_io_port_assertions.sv]
`timescale 1ns/100ps
`default_nettype none
module muxed_io_port_assertions #(
	parameter WIDTH = 8,
	parameter ADDR_LINES_PRESENT = 1
)(
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic avs_waitrequest_o,
	input wire logic [WIDTH-1:0] pin_out_o,
	input wire logic [WIDTH-1:0] pin_oe_o,
	input wire logic ext_mem_en_i,
	input wire logic [3:0] ext_addr_hi_i,
	input wire logic [3:0] analog_channel_sel_o,
	input wire logic [3:0] analog_port_config_field_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	// ==========
	// Handshake
	sequence s_req;
		(avs_read_i || avs_write_i) && avs_waitrequest_o;
	endsequence
	sequence s_ack;
		!avs_waitrequest_o ##1 avs_waitrequest_o;
	endsequence
	AST_ACCEPT: assert property (s_req |=> s_ack) else $error("request not taken in one cycle");
	AST_WAIT_CAUSE: assert property ($fell(avs_waitrequest_o) |-> $past(avs_read_i || avs_write_i))
		else $error("accept without request");
	AST_IDLE_WAIT: assert property (!avs_read_i && !avs_write_i |=> avs_waitrequest_o)
		else $error("accept while idle");
	AST_UPPER_ZERO: assert property (!avs_waitrequest_o |-> avs_readdata_o[31:8] == 24'h0)
		else $error("read data wider than port");
	// ==========
	// Pins
	// Reset must free the pins by the next edge, so this one stays armed during reset
	AST_RST_OFF: assert property (disable iff (1'b0) rst_i |=> pin_oe_o == 0 && avs_waitrequest_o)
		else $error("pins driven in reset");
	AST_EXT_ADDR: assert property (ADDR_LINES_PRESENT != 0 && $past(!rst_i) && $past(ext_mem_en_i)
		|-> pin_oe_o[3:0] == 4'hF && pin_out_o[3:0] == $past(ext_addr_hi_i))
		else $error("address lines not on pins");
	AST_ANALOG_SEL: assert property ($past(!rst_i) && $stable(analog_port_config_field_o)
		|-> analog_channel_sel_o == ((analog_port_config_field_o <= 4'h2) ? 4'hF : 4'h0))
		else $error("analog select wrong");
	AST_ANALOG_READ: assert property (avs_read_i && avs_address_i == 4'h0 && !avs_waitrequest_o
		&& $stable(analog_channel_sel_o) |-> (avs_readdata_o[7:4] & analog_channel_sel_o) == 4'h0)
		else $error("analog pin read as digital");
endmodule // muxed_io_port_assertions
bind muxed_io_port muxed_io_port_assertions #(.WIDTH(WIDTH), .ADDR_LINES_PRESENT(ADDR_LINES_PRESENT)) chk_inst (
	.ref_clk_i(ref_clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
	.avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
	.pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o), .ext_mem_en_i(ext_mem_en_i), .ext_addr_hi_i(ext_addr_hi_i),
	.analog_channel_sel_o(analog_channel_sel_o), .analog_port_config_field_o(analog_port_config_field_o));
`default_nettype wire

// [testbench/pin_board_model.sv]
`timescale 1ns/100ps
`default_nettype none
module pin_board_model #(
	parameter WIDTH = 8
)(
	input wire logic [WIDTH-1:0] pin_out_i,
	input wire logic [WIDTH-1:0] pin_oe_i,
	input wire logic [WIDTH-1:0] board_drive_i,
	output logic [WIDTH-1:0] level_o
);
	// Board holds every pin the port floats, so no pin reads unknown
	always_comb
	begin
		for (int k = 0; k < WIDTH; k++)
			level_o[k] = pin_oe_i[k] ? pin_out_i[k] : board_drive_i[k];
	end
endmodule // pin_board_model
`default_nettype wire

// [testbench/muxed_io_port_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module muxed_io_port_tb;
	logic ref_clk = 0, rst = 1, rd = 0, wr = 0, ext_en = 0, sd = 0, wreq;
	logic [3:0] addr = 4'h0, ext_a = 4'h0, pwm = 4'h0, asel, afld;
	logic [31:0] wdat = 32'h0, rdat, q;
	logic [7:0] out, oe, lvl, drv = 8'h5A;
	int err_count = 0, n_compared = 0;
	always #5 ref_clk = ~ref_clk;
	muxed_io_port muxed_io_port_inst (.ref_clk_i(ref_clk), .rst_i(rst), .avs_address_i(addr),
		.avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(4'hF),
		.avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .pin_in_i(lvl), .pin_out_o(out), .pin_oe_o(oe),
		.ext_mem_en_i(ext_en), .ext_addr_hi_i(ext_a), .pwm3_channel_c_i(pwm[0]), .pwm3_channel_b_i(pwm[1]),
		.pwm1_channel_c_i(pwm[2]), .pwm1_channel_b_i(pwm[3]), .pwm_shutdown_i(sd),
		.analog_channel_sel_o(asel), .analog_port_config_field_o(afld));
	pin_board_model pin_board_model_inst (.pin_out_i(out), .pin_oe_i(oe), .board_drive_i(drv), .level_o(lvl));
	// ==========
	// Tasks
	task bus(input logic w, input logic [3:0] a, input logic [7:0] d);
		int n;
		begin
			@(posedge ref_clk);
			addr <= a;
			wdat <= {24'h0, d};
			wr <= w;
			rd <= !w;
			n = 0;
			@(negedge ref_clk);
			while (wreq !== 1'b0 && n < 20)
			begin
				@(negedge ref_clk);
				n++;
			end
			if (n == 20)
			begin
				err_count++;
				$display("Error at %0t: no answer", $time);
			end
			@(posedge ref_clk);
			q = rdat;
			wr <= 0;
			rd <= 0;
		end
	endtask
	task chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			err_count++;
			$display("Error at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	// Pins follow registers one edge late and are sampled one edge late
	task settle;
		repeat (3) @(posedge ref_clk);
		@(negedge ref_clk);
	endtask
	task end_sim;
		$display("Compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// ==========
	// Tests
	initial
	begin
		repeat (16) @(posedge ref_clk);
		rst <= 0;
		@(negedge ref_clk);
		chk(oe, 8'h00);
		bus(0, 4'h8, 8'h00);
		chk(q[7:0], 8'hFF);
		bus(0, 4'h4, 8'h00);
		chk(q[7:0], 8'h00);
		chk({4'h0, asel}, 8'h0F);
		$display("reset test done");
		bus(1, 4'hC, 8'hF2);
		bus(1, 4'h0, 8'hA5);
		bus(1, 4'h8, 8'h3C);
		bus(1, 4'h2, 8'hFF);
		settle;
		chk(oe, 8'hC3);
		chk(out & oe, 8'h81);
		bus(0, 4'h4, 8'h00);
		chk(q[7:0], 8'hA5);
		bus(0, 4'h0, 8'h00);
		chk(q[7:0], 8'h99);
		bus(0, 4'h1, 8'h00);
		chk(q[7:0], 8'h00);
		$display("port test done");
		ext_a <= 4'h9;
		ext_en <= 1;
		settle;
		chk(oe, 8'hCF);
		chk(out & 8'h0F, 8'h09);
		@(posedge ref_clk);
		ext_en <= 0;
		$display("address test done");
		bus(1, 4'h8, 8'h00);
		pwm <= 4'b1001;
		bus(1, 4'hC, 8'hF0);
		settle;
		chk(out, 8'h95);
		chk(oe, 8'hFF);
		bus(1, 4'hC, 8'hF4);
		sd <= 1;
		settle;
		chk(oe, 8'h0F);
		bus(1, 4'hC, 8'hF2);
		sd <= 0;
		settle;
		chk(out, 8'hA5);
		$display("pwm test done");
		bus(1, 4'hC, 8'h20);
		settle;
		chk({4'h0, asel}, 8'h0F);
		chk(oe, 8'hFF);
		bus(0, 4'h0, 8'h00);
		chk(q[7:0], 8'h05);
		bus(1, 4'hC, 8'h30);
		settle;
		chk({4'h0, asel}, 8'h00);
		chk({4'h0, afld}, 8'h03);
		$display("analog test done");
		end_sim;
	end
	initial
	begin
		#20000;
		$display("Error at %0t: watchdog", $time);
		err_count++;
		end_sim;
	end
endmodule // muxed_io_port_tb
`default_nettype wire
